// ===== wwd_pkg.sv
`default_nettype none
package wwd_pkg;
  localparam int unsigned LOW_POWER_RC_CLOCK_HZ = 31000;
  localparam int unsigned SYS_HZ = 100_000_000;
  localparam int unsigned PRESC_SHORT = 32;
  localparam int unsigned PRESC_LONG = 128;
  localparam int unsigned BASE_SHORT_MS = 1;
  localparam int unsigned BASE_LONG_MS = 4;
  localparam int unsigned PRE_W = 7;
  localparam int unsigned POST_W = 15;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned ELAP_W = PRE_W + POST_W;
  localparam logic [PRE_W-1:0] PRE_LAST_SHORT = PRE_W'(PRESC_SHORT - 1);
  localparam logic [PRE_W-1:0] PRE_LAST_LONG = PRE_W'(PRESC_LONG - 1);
  localparam logic [SEL_W-1:0] PS_MAX = 4'hF;
  localparam logic [POST_W-1:0] POST_ONES = 15'h7FFF;

  localparam logic [31:0] REG_CONFIG = 32'h0000_0000;
  localparam logic [31:0] REG_CONTROL = 32'h0000_0004;
  localparam logic [31:0] REG_COMMAND = 32'h0000_0008;
  localparam logic [31:0] REG_STATUS = 32'h0000_000C;

  localparam int unsigned CFG_PS_LSB = 0;
  localparam int unsigned CFG_PRESEL_BIT = 4;
  localparam int unsigned CFG_WINDOW_DISABLE_BIT_BIT = 6;
  localparam int unsigned CFG_HWEN_BIT = 7;
  localparam logic [7:0] CFG_RESET = 8'h40;
  localparam int unsigned CTL_SWEN_BIT = 5;
  localparam int unsigned CTL_WATCHDOG_TIMEOUT_FLAG_BIT = 4;
  localparam int unsigned CTL_SLEEP_BIT = 3;
  localparam int unsigned CTL_IDLE_BIT = 2;
  localparam int unsigned CMD_CLR_BIT = 0;
  localparam int unsigned CMD_SLEEP_BIT = 1;
  localparam int unsigned CMD_IDLE_BIT = 2;
  localparam int unsigned CMD_CSW_BIT = 3;
  localparam int unsigned STS_MODE_LSB = 24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_IDLE} wwd_mode_e;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } wwd_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wwd_axi_rsp_s;

  typedef struct packed {
    logic [2:0] stages;
    logic level;
  } wwd_sync_s;
endpackage
`default_nettype wire

// ===== wwd_sync.sv
`default_nettype none
module wwd_sync
  import wwd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic async_in,
  output logic level
);
  wwd_sync_s state_q;
  wwd_sync_s state_d;

  // A change is accepted only once the second and third stages agree.
  always_comb
  begin
    state_d = state_q;
    state_d.stages = {state_q.stages[1:0], async_in};
    if (state_q.stages[2] == state_q.stages[1])
    begin
      state_d.level = state_q.stages[2];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign level = state_q.level;
endmodule
`default_nettype wire

// ===== wwd_top.sv
// The implementer's own choices: the address map and register access over AXI4-Lite.
`default_nettype none
// Behaviour
// R1: Watchdog counts low-power RC clock edges; enabling it enables that clock.
// R2: Prescaler divides by 32 or 128 per prescale_select_bit.
// R3: Nominal base time-out is about 1 ms (/32) or 4 ms (/128).
// R4: Postscaler divides further with 16 settings, 1:1 to 1:32768.
// R5: Postscale setting n selects a ratio of two to the power n.
// R6: Reset, sleep/idle entry and exit, and clear instruction clear all counters.
// R7: Completion of any clock switch also clears the counters.
// R8: Counting continues in sleep/idle; a time-out there wakes the device.
// R9: Software clears the sleep and idle flags after a wake-up.
// R10: Time-out sets a sticky flag that only software clears.
// R11: Time-out in normal execution raises a device reset.
// R12: Windowed mode: clear restarts only in the final quarter of the period.
// R13: Windowed mode: earlier clear causes a reset like a time-out.
// R14: Windowed mode is on when window_disable_bit is zero.
// R15: config_watchdog_on set keeps the watchdog always running.
// R16: With config_watchdog_on clear, soft_watchdog_on turns it on and off.
// R17: Every device reset clears soft_watchdog_on.
module wwd_top
  import wwd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic low_power_rc_clock,
  input wire logic clock_switch_done,
  input wire logic wake_event,
  input wire wwd_axi_req_s axi_req,
  output wwd_axi_rsp_s axi_rsp,
  output logic low_power_rc_clock_enable,
  output logic watchdog_reset,
  output logic wake_pulse
);
  typedef struct packed {
    logic [7:0] cfg;
    logic soft_watchdog_on;
    logic watchdog_timeout_flag;
    logic sleep_flag;
    logic idle_flag;
    wwd_mode_e mode;
    logic [PRE_W-1:0] pre;
    logic [POST_W-1:0] post;
    logic lvl_prev;
    logic aw_got;
    logic w_got;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    wwd_axi_rsp_s rsp;
    logic low_power_rc_clock_en;
    logic wdt_reset;
    logic wake;
  } wwd_state_s;

  wwd_state_s state_q;
  wwd_state_s state_d;
  logic rc_level;
  logic tick;
  logic run;
  logic enabled;
  logic win_on;
  logic [SEL_W-1:0] ps_sel;
  logic [PRE_W-1:0] pre_last;
  logic [POST_W-1:0] post_last;
  logic [ELAP_W-1:0] elapsed;
  localparam int unsigned PER_W = ELAP_W + 1;
  logic [PER_W-1:0] period;
  logic in_win;
  logic pre_end;
  logic timeout;
  logic wr_go;
  logic wr_cmd;
  logic clr_cmd;
  logic fault;
  logic sleep_cmd;
  logic idle_cmd;
  logic csw;
  logic exit_ps;
  logic kill;
  logic [31:0] rd_word;
  logic rd_ok;

  wwd_sync u_rc_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in(low_power_rc_clock),
    .level(rc_level)
  );

  assign tick = rc_level & ~state_q.lvl_prev;
  assign run = state_q.mode == MODE_RUN;
  assign enabled = state_q.cfg[CFG_HWEN_BIT] | state_q.soft_watchdog_on; // R15 R16
  assign win_on = ~state_q.cfg[CFG_WINDOW_DISABLE_BIT_BIT]; // R14
  assign ps_sel = state_q.cfg[CFG_PS_LSB +: SEL_W];
  // Terminal counts: prescaler 31 or 127, postscaler 2^n - 1.
  assign pre_last = state_q.cfg[CFG_PRESEL_BIT] ? PRE_LAST_LONG : PRE_LAST_SHORT; // R2 R3
  assign post_last = POST_ONES >> (PS_MAX - ps_sel); // R4 R5

  // Elapsed and full period in prescaler input edges, for the window test.
  assign elapsed = state_q.cfg[CFG_PRESEL_BIT]
                   ? {state_q.post, state_q.pre}
                   : ELAP_W'({state_q.post, state_q.pre[4:0]});
  // One bit wider than the elapsed count: /128 with n=15 is exactly 2^ELAP_W edges.
  assign period = PER_W'({1'b0, pre_last} + 8'h01) << ps_sel;
  assign in_win = {1'b0, elapsed} >= (period - (period >> 2)); // R12

  assign pre_end = tick & enabled & (state_q.pre == pre_last); // R1 R2
  assign timeout = pre_end & (state_q.post == post_last);

  assign wr_go = state_q.aw_got & state_q.w_got;
  assign wr_cmd = wr_go & (state_q.awaddr == REG_COMMAND) & state_q.wstrb[0];
  assign clr_cmd = wr_cmd & state_q.wdata[CMD_CLR_BIT] & run;
  assign fault = clr_cmd & enabled & win_on & ~in_win; // R13
  assign sleep_cmd = wr_cmd & state_q.wdata[CMD_SLEEP_BIT] & run;
  assign idle_cmd = wr_cmd & state_q.wdata[CMD_IDLE_BIT] & run & ~sleep_cmd;
  assign csw = clock_switch_done | (wr_cmd & state_q.wdata[CMD_CSW_BIT]); // R7
  assign exit_ps = ~run & (timeout | wake_event);
  // Any of these restarts the whole chain; a stopped watchdog stays at zero.
  assign kill = ~enabled | clr_cmd | sleep_cmd | idle_cmd | csw | exit_ps | timeout; // R6

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (axi_req.araddr)
      REG_CONFIG:
      begin
        rd_word[7:0] = state_q.cfg;
      end
      REG_CONTROL:
      begin
        rd_word[CTL_SWEN_BIT] = state_q.soft_watchdog_on;
        rd_word[CTL_WATCHDOG_TIMEOUT_FLAG_BIT] = state_q.watchdog_timeout_flag;
        rd_word[CTL_SLEEP_BIT] = state_q.sleep_flag;
        rd_word[CTL_IDLE_BIT] = state_q.idle_flag;
      end
      REG_COMMAND:
      begin
        rd_word = 32'h0000_0000;
      end
      REG_STATUS:
      begin
        rd_word[ELAP_W-1:0] = elapsed;
        rd_word[STS_MODE_LSB +: 2] = state_q.mode;
      end
      default:
      begin
        rd_ok = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    state_d = state_q;
    state_d.lvl_prev = rc_level;
    state_d.low_power_rc_clock_en = enabled; // R1
    state_d.wdt_reset = 1'b0;
    state_d.wake = 1'b0;

    // Write address and data may arrive in either order; each is held until both are in.
    if (axi_req.awvalid && state_q.rsp.awready)
    begin
      state_d.aw_got = 1'b1;
      state_d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && state_q.rsp.wready)
    begin
      state_d.w_got = 1'b1;
      state_d.wdata = axi_req.wdata;
      state_d.wstrb = axi_req.wstrb;
    end
    if (state_q.rsp.bvalid && axi_req.bready)
    begin
      state_d.rsp.bvalid = 1'b0;
    end
    if (wr_go)
    begin
      state_d.aw_got = 1'b0;
      state_d.w_got = 1'b0;
      state_d.rsp.bvalid = 1'b1;
      state_d.rsp.bresp = RESP_OKAY;
      if (state_q.awaddr == REG_CONFIG && state_q.wstrb[0])
      begin
        state_d.cfg = state_q.wdata[7:0];
      end
      else if (state_q.awaddr == REG_CONTROL && state_q.wstrb[0])
      begin
        state_d.soft_watchdog_on = state_q.wdata[CTL_SWEN_BIT]; // R16
        state_d.watchdog_timeout_flag = state_q.wdata[CTL_WATCHDOG_TIMEOUT_FLAG_BIT]; // R10
        state_d.sleep_flag = state_q.wdata[CTL_SLEEP_BIT]; // R9
        state_d.idle_flag = state_q.wdata[CTL_IDLE_BIT]; // R9
      end
      else if (state_q.awaddr != REG_CONFIG && state_q.awaddr != REG_CONTROL
               && state_q.awaddr != REG_COMMAND && state_q.awaddr != REG_STATUS)
      begin
        state_d.rsp.bresp = RESP_SLVERR;
      end
    end
    state_d.rsp.awready = ~state_d.aw_got & ~state_d.rsp.bvalid;
    state_d.rsp.wready = ~state_d.w_got & ~state_d.rsp.bvalid;

    if (state_q.rsp.rvalid && axi_req.rready)
    begin
      state_d.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && state_q.rsp.arready)
    begin
      state_d.rsp.rvalid = 1'b1;
      state_d.rsp.rdata = rd_word;
      state_d.rsp.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    state_d.rsp.arready = ~state_d.rsp.rvalid;

    // Counting chain; hardware events below override software writes above.
    if (tick && enabled)
    begin
      state_d.pre = pre_end ? '0 : state_q.pre + 1'b1; // R2
      if (pre_end)
      begin
        state_d.post = state_q.post + 1'b1; // R4
      end
    end
    if (kill)
    begin
      state_d.pre = '0; // R6 R7
      state_d.post = '0; // R6 R7
    end

    if ((timeout && run) || fault)
    begin
      state_d.wdt_reset = 1'b1; // R11 R13
      state_d.watchdog_timeout_flag = 1'b1; // R10
      state_d.soft_watchdog_on = 1'b0; // R17
    end
    else if (sleep_cmd)
    begin
      state_d.mode = MODE_SLEEP;
      state_d.sleep_flag = 1'b1;
    end
    else if (idle_cmd)
    begin
      state_d.mode = MODE_IDLE;
      state_d.idle_flag = 1'b1;
    end
    if (exit_ps)
    begin
      // Flags stay set: software must clear them after waking.
      state_d.mode = MODE_RUN; // R8
      state_d.wake = 1'b1; // R8
      if (timeout)
      begin
        state_d.watchdog_timeout_flag = 1'b1; // R10
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_q <= '0; // R17
      state_q.cfg <= CFG_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign axi_rsp = state_q.rsp;
  assign low_power_rc_clock_enable = state_q.low_power_rc_clock_en;
  assign watchdog_reset = state_q.wdt_reset;
  assign wake_pulse = state_q.wake;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_tmo_sets_flag: assert property (timeout |=> state_q.watchdog_timeout_flag) // R10
    else $error("time-out did not set the flag");
  a_flag_sticky: assert property (state_q.watchdog_timeout_flag && !wr_go
                                  |=> state_q.watchdog_timeout_flag) // R10
    else $error("time-out flag cleared without a write");
  a_run_tmo_reset: assert property (timeout && run |=> watchdog_reset
                                    && !state_q.soft_watchdog_on) // R11
    else $error("run time-out gave no reset");
  a_sleep_tmo_wake: assert property (timeout && !run
                                     |=> wake_pulse && state_q.mode == MODE_RUN
                                     && !watchdog_reset) // R8
    else $error("time-out in power save did not wake");
  a_early_clr_rst: assert property (clr_cmd && enabled && win_on && !in_win
                                    |=> watchdog_reset) // R13
    else $error("early clear did not reset");
  a_win_clr_ok: assert property (clr_cmd && (!win_on || in_win)
                                 |=> !watchdog_reset && state_q.pre == '0
                                 && state_q.post == '0) // R12
    else $error("clear in window did not restart");
  a_psave_clears: assert property (sleep_cmd || idle_cmd || exit_ps
                                   |=> state_q.pre == '0 && state_q.post == '0) // R6
    else $error("power-save change left counts");
  a_csw_clears: assert property (clock_switch_done
                                 |=> state_q.pre == '0 && state_q.post == '0) // R7
    else $error("clock switch left counts");
  a_pre_wrap: assert property (pre_end && !kill
                               |=> state_q.pre == '0
                               && state_q.post == $past(state_q.post) + 1'b1) // R2
    else $error("prescaler wrap wrong");
  a_hw_enable: assert property (state_q.cfg[CFG_HWEN_BIT] |=> low_power_rc_clock_enable) // R15
    else $error("hardware enable ignored");
  a_soft_off: assert property (!state_q.cfg[CFG_HWEN_BIT] && !state_q.soft_watchdog_on
                               |=> !low_power_rc_clock_enable ##0 state_q.pre == '0) // R16
    else $error("disabled watchdog still runs");
  a_low_power_rc_clock_follows: assert property (enabled |=> low_power_rc_clock_enable) // R1
    else $error("clock source not enabled with the watchdog");
  a_pre_counts: assert property (tick && enabled && !pre_end && !kill
                                 |=> state_q.pre == $past(state_q.pre) + 1'b1) // R1 R2
    else $error("prescaler missed an edge");
  a_wake_clears: assert property (wake_event && !run
                                  |=> wake_pulse && state_q.mode == MODE_RUN
                                  && state_q.pre == '0 && state_q.post == '0) // R6 R8
    else $error("wake-up did not restart the count");
  a_fault_sets_flag: assert property (fault |=> state_q.watchdog_timeout_flag
                                      && !state_q.soft_watchdog_on) // R10 R13
    else $error("early clear left no flag");
  a_window_disable_bit_no_fault: assert property (clr_cmd && !win_on && !timeout
                                      |=> !watchdog_reset) // R14
    else $error("clear with window off gave a reset");
  a_sleep_entry: assert property (sleep_cmd && !fault && !timeout
                                  |=> state_q.mode == MODE_SLEEP && state_q.sleep_flag) // R8
    else $error("sleep command not taken");
  a_idle_entry: assert property (idle_cmd && !fault && !timeout
                                 |=> state_q.mode == MODE_IDLE && state_q.idle_flag) // R8
    else $error("idle command not taken");

  c_run_reset: cover property (timeout && run ##1 watchdog_reset);
  c_sleep_wake: cover property (state_q.mode == MODE_SLEEP && timeout ##1 wake_pulse);
  c_win_clear: cover property (clr_cmd && win_on && in_win);
  c_early_clear: cover property (fault);
  c_wake_event: cover property (wake_event && !run ##1 wake_pulse);
endmodule
`default_nettype wire

// ===== wwd_core_model.sv
`default_nettype none
module wwd_core_model
  import wwd_pkg::*;
(
  input wire logic clk_sys,
  input wire wwd_axi_rsp_s axi_rsp,
  output var wwd_axi_req_s axi_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cycles the core waits before it will take read data, to exercise a slow reader.
  int stall = 0;

  initial axi_req = '0;

  task automatic write_word(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (axi_req.awvalid && axi_rsp.awready)
        axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready)
        axi_req.wvalid <= 1'b0;
    end while (axi_rsp.bvalid !== 1'b1);
    r = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask

  task automatic read_word(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= (stall == 0);
    do
    begin
      @(posedge clk_sys);
      n++;
      if (axi_req.arvalid && axi_rsp.arready)
        axi_req.arvalid <= 1'b0;
      if (n >= stall)
        axi_req.rready <= 1'b1;
    end while (!(axi_req.rready && axi_rsp.rvalid === 1'b1));
    d = axi_rsp.rdata;
    r = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask

  // Only reset drops the flags in hardware, so software must do it after every wake-up.
  task automatic clear_status(output logic [1:0] r);
    write_word(REG_CONTROL, 32'h0000_0000, r);
  endtask
endmodule
`default_nettype wire

// ===== test_windowed_watchdog_timer.sv
`default_nettype none
module test_windowed_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import wwd_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic low_power_rc_clock = 1'b0;
  logic clock_switch_done = 1'b0;
  logic wake_event = 1'b0;
  wwd_axi_req_s axi_req;
  wwd_axi_rsp_s axi_rsp;
  logic low_power_rc_clock_enable;
  logic watchdog_reset;
  logic wake_pulse;
  int fail_count = 0;
  int check_count = 0;
  int rc_cnt = 0;
  int rst_cnt = 0;
  int t;
  logic [7:0] lfsr = 8'h38;
  logic [31:0] rdat;
  logic [1:0] resp;
  logic [1:0] kind;

  wwd_top wwd_top_inst (.clk_sys(clk_sys), .reset(reset),
    .low_power_rc_clock(low_power_rc_clock), .clock_switch_done(clock_switch_done),
    .wake_event(wake_event), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .low_power_rc_clock_enable(low_power_rc_clock_enable), .watchdog_reset(watchdog_reset), .wake_pulse(wake_pulse));
  wwd_core_model wwd_core_model_inst (.clk_sys(clk_sys), .axi_rsp(axi_rsp), .axi_req(axi_req));

  always #5 clk_sys = ~clk_sys;

  // A fast RC clock keeps periods short: one RC period is 16 system clocks.
  always @(posedge clk_sys)
  begin
    rc_cnt <= (rc_cnt == 7) ? 0 : rc_cnt + 1;
    if (rc_cnt == 7)
      low_power_rc_clock <= ~low_power_rc_clock;
  end

  // The reset pulse of a rejected clear stands while the write task is still busy.
  always @(posedge clk_sys)
  begin
    if (watchdog_reset === 1'b1)
      rst_cnt <= rst_cnt + 1;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  function automatic int exp_clk(input logic presel, input logic [3:0] n);
    return (presel ? PRESC_LONG : PRESC_SHORT) * (1 << n) * 16;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: seen %08h expected %08h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    wwd_core_model_inst.write_word(a, d, resp);
  endtask

  task automatic rd(input logic [31:0] a);
    wwd_core_model_inst.read_word(a, rdat, resp);
  endtask

  task automatic wait_evt(input int lim, output int n, output logic [1:0] k);
    n = 0;
    k = 2'b00;
    while (n < lim && k == 2'b00)
    begin
      @(posedge clk_sys);
      n++;
      k = {watchdog_reset, wake_pulse};
    end
  endtask

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #1_000_000;
    fail_count++;
    final_report();
  end

  initial
  begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rd(REG_CONFIG);
    check(rdat, 32'h0000_0040);
    rd(REG_CONTROL);
    check(rdat, 32'h0000_0000);
    check(low_power_rc_clock_enable, 1'b0);
    rd(32'h0000_0010);
    check(resp, RESP_SLVERR);
    wr(REG_CONTROL, 32'h0000_0020);
    repeat (2) @(posedge clk_sys);
    check(low_power_rc_clock_enable, 1'b1);
    wait_evt(700, t, kind);
    check(kind, 2'b10);
    check(t >= 480 && t <= 560, 1'b1);
    rd(REG_CONTROL);
    check(rdat, 32'h0000_0010);
    wwd_core_model_inst.clear_status(resp);
    rd(REG_CONTROL);
    check(rdat, 32'h0000_0000);
    for (int i = 0; i < 3; i++)
    begin
      lfsr = lfsr_next(lfsr);
      wwd_core_model_inst.stall = int'(lfsr[4:3]);
      wr(REG_CONFIG, {24'h0, 3'b110, lfsr[0], 2'b00, lfsr[2:1]});
      wr(REG_COMMAND, 32'h0000_0001);
      wait_evt(17000, t, kind);
      check(kind, 2'b10);
      check(t + 32 >= exp_clk(lfsr[0], {2'b0, lfsr[2:1]}), 1'b1);
      check(t <= exp_clk(lfsr[0], {2'b0, lfsr[2:1]}) + 32, 1'b1);
      rd(REG_CONTROL);
      check(rdat, 32'h0000_0010);
    end
    wr(REG_CONFIG, 32'h0000_0080);
    t = rst_cnt;
    wr(REG_COMMAND, 32'h0000_0001);
    @(posedge clk_sys);
    check(rst_cnt - t, 32'h0000_0001);
    wait_evt(20, t, kind);
    check(kind, 2'b00);
    repeat (440) @(posedge clk_sys);
    wr(REG_COMMAND, 32'h0000_0001);
    wait_evt(100, t, kind);
    check(kind, 2'b00);
    wait_evt(600, t, kind);
    check(kind, 2'b10);
    check(t >= 380 && t <= 444, 1'b1);
    wr(REG_CONFIG, 32'h0000_00C0);
    for (int i = 0; i < 2; i++)
    begin
      wwd_core_model_inst.clear_status(resp);
      wr(REG_COMMAND, 32'h2 << i);
      wait_evt(700, t, kind);
      check(kind, 2'b01);
      check(t >= 480 && t <= 560, 1'b1);
      rd(REG_CONTROL);
      check(rdat, 32'h10 | (32'h8 >> i));
      rd(REG_STATUS);
      check(rdat[25:24], 2'b00);
    end
    wwd_core_model_inst.clear_status(resp);
    wr(REG_COMMAND, 32'h0000_0002);
    repeat (50) @(posedge clk_sys);
    wake_event <= 1'b1;
    @(posedge clk_sys);
    wake_event <= 1'b0;
    wait_evt(20, t, kind);
    check(kind, 2'b01);
    rd(REG_STATUS);
    check(rdat[21:0] < 2, 1'b1);
    check(rdat[25:24], 2'b00);
    for (int i = 0; i < 3; i++)
    begin
      repeat (300) @(posedge clk_sys);
      rd(REG_STATUS);
      check(rdat[21:0] > 10, 1'b1);
      if (i == 0)
      begin
        clock_switch_done <= 1'b1;
        @(posedge clk_sys);
        clock_switch_done <= 1'b0;
      end
      else
        wr(REG_COMMAND, (i == 1) ? 32'h8 : 32'h1);
      rd(REG_STATUS);
      check(rdat[21:0] < 2, 1'b1);
    end
    wr(REG_CONFIG, 32'h0000_0040);
    wr(REG_CONTROL, 32'h0000_0000);
    wait_evt(700, t, kind);
    check(kind, 2'b00);
    check(low_power_rc_clock_enable, 1'b0);
    wr(REG_CONTROL, 32'h0000_0020);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rd(REG_CONTROL);
    check(rdat, 32'h0000_0000);
    final_report();
  end
endmodule
`default_nettype wire
